// File: src/plpm_regs.vh
// Purpose: Constants for the link power management configuration block
// Assumes: 25 MHz system clock, 32-bit classic Wishbone register bus
// Notes:   Offsets are byte addresses of aligned 32-bit words
`ifndef PLPM_REGS_VH
`define PLPM_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PLPM_OFF_CTRL       8'h00
`define PLPM_OFF_L0S_CFG    8'h04
`define PLPM_OFF_FTS_CFG    8'h08
`define PLPM_OFF_LAT_CFG    8'h0c
`define PLPM_OFF_DEVCAP     8'h10
`define PLPM_OFF_LNKCAP     8'h14
`define PLPM_OFF_STATUS     8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PLPM_CTRL_INT_PHY   0
`define PLPM_CTRL_SEP_CLK   1
`define PLPM_CTRL_L1_EN     2
`define PLPM_DEVCAP_L0S_LSB 6
`define PLPM_DEVCAP_L1_LSB  9
`define PLPM_LNKCAP_ASPM_L1 11
`define PLPM_LNKCAP_L0SX_LSB 12
`define PLPM_LNKCAP_L1X_LSB 15

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PLPM_RST_CTRL       3'h0
`define PLPM_RST_L0S_STEP   5'h1f
`define PLPM_RST_FTS_CC     8'hc8
`define PLPM_RST_FTS_SC     8'hff
`define PLPM_RST_LAT        3'h7
`define PLPM_MAX_L0S_STEP   5'h1f
`define PLPM_MAX_FTS        8'hff
`define PLPM_MAX_LAT        3'h7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PLPM_CLK_MHZ        25
`define PLPM_L0S_STEP_NS    256
// 256 ns at 40 ns per cycle, rounded up: a least time
`define PLPM_L0S_STEP_CYC   ((`PLPM_L0S_STEP_NS * `PLPM_CLK_MHZ + 999) / 1000)
// One fast training sequence is 16 ns; exit latency in ns per FTS
`define PLPM_FTS_NS         12'h010

`endif

// File: src/plpm_top.v
// Purpose: Link power management configuration and L0s entry timer
// Assumes: Classic Wishbone slave; link idle/activity comes from same clock
// Notes:   Capability fields are read-only; writes to them are dropped
//
// How it works
// R1: Enter L0s after idle threshold, 256ns steps. The code uses 7-cycle steps of 280 ns.
// R2: Integrated PHY forces idle threshold to maximum.
// R3: Read-only L0s acceptable latency field holds setting.
// R4: Common clock: send FTS count, derive L0s exit.
// R5: Separate clock: own FTS count, same use.
// R6: L1 ASPM support bit follows enable option.
// R7: Integrated PHY forces L1 ASPM support off.
// R8: Read-only L1 acceptable latency field holds setting.
// R9: L1 exit latency chosen per clock mode.
// R10: Latencies use 3-bit codes; capability writes ignored.
`timescale 1ns/1ps
`default_nettype none
`include "plpm_regs.vh"

module plpm_top
(
    input  wire        i_sys_clk,
    input  wire        i_reset,
    input  wire [7:0]  i_wb_adr,
    input  wire [31:0] i_wb_dat,
    input  wire [3:0]  i_wb_sel,
    input  wire        i_wb_we,
    input  wire        i_wb_cyc,
    input  wire        i_wb_stb,
    input  wire        i_link_idle,
    input  wire        i_link_init,
    output reg  [31:0] o_wb_dat,
    output reg         o_wb_ack,
    output reg         o_tx_l0s,
    output reg  [7:0]  o_fts_count,
    output reg  [2:0]  o_l0s_exit_lat,
    output reg  [2:0]  o_l1_exit_lat,
    output reg         o_aspm_l1_sup
);

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    reg [2:0]  ctrl_r;
    reg [4:0]  l0s_step_r;
    reg [7:0]  fts_cc_r;
    reg [7:0]  fts_sc_r;
    reg [2:0]  l0s_acc_r;
    reg [2:0]  l1_acc_r;
    reg [2:0]  l1x_cc_r;
    reg [2:0]  l1x_sc_r;
    reg [7:0]  fts_sent_r;
    reg [12:0] idle_cnt_r;
    reg [12:0] idle_cnt_nxt;
    reg [5:0]  step_cnt_r;

    wire int_phy = ctrl_r[`PLPM_CTRL_INT_PHY];
    wire sep_clk = ctrl_r[`PLPM_CTRL_SEP_CLK];

    // ------------------------------------------------------------
    // L0s exit latency code
    // ------------------------------------------------------------
    // Map an FTS count onto the 3-bit L0s exit latency code:
    // <64, <128, <256, <512, <1us, <2us, >=2us; code 7 is never produced
    function [2:0] plpm_fts_code;
        input [7:0] fts;
        reg   [11:0] ns;
        begin
            ns = {4'h0, fts} * `PLPM_FTS_NS;
            if (ns < 12'h040)
                plpm_fts_code = 3'h0;
            else if (ns < 12'h080)
                plpm_fts_code = 3'h1;
            else if (ns < 12'h100)
                plpm_fts_code = 3'h2;
            else if (ns < 12'h200)
                plpm_fts_code = 3'h3;
            else if (ns < 12'h3e8)
                plpm_fts_code = 3'h4;
            else if (ns < 12'h7d0)
                plpm_fts_code = 3'h5;
            else
                plpm_fts_code = 3'h6;
        end
    endfunction

    // ------------------------------------------------------------
    // Effective settings
    // ------------------------------------------------------------
    wire [4:0] l0s_step = int_phy ? `PLPM_MAX_L0S_STEP : l0s_step_r;          // [R2]
    wire [7:0] fts_eff  = int_phy ? `PLPM_MAX_FTS : (sep_clk ? fts_sc_r : fts_cc_r); // [R4] [R5]
    wire [2:0] l1x_eff  = int_phy ? `PLPM_MAX_LAT : (sep_clk ? l1x_sc_r : l1x_cc_r); // [R9]
    wire       aspm_l1  = ctrl_r[`PLPM_CTRL_L1_EN] & ~int_phy;                 // [R6] [R7]
    wire [2:0] l0sx     = plpm_fts_code(fts_eff);                              // [R4] [R5] [R10]
    // Threshold in 7-cycle ticks: step code n means (n+1)*280 ns
    wire [12:0] thresh  = {8'h00, l0s_step} + 13'h0001;                       // [R1]

    wire [31:0] devcap = {26'h0, l1_acc_r, l0s_acc_r} << `PLPM_DEVCAP_L0S_LSB; // [R3] [R8]
    wire [31:0] lnkcap = ({31'h0, aspm_l1} << `PLPM_LNKCAP_ASPM_L1)
                       | ({29'h0, l0sx} << `PLPM_LNKCAP_L0SX_LSB)
                       | ({29'h0, l1x_eff} << `PLPM_LNKCAP_L1X_LSB);

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    wire wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    wire wb_wr  = wb_req & i_wb_we;
    // Writes land at the edge that takes the request; ack follows a cycle later.
    // Capability words have no write case, so software cannot alter them.

    always @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            ctrl_r     <= `PLPM_RST_CTRL;
            l0s_step_r <= `PLPM_RST_L0S_STEP;
            fts_cc_r   <= `PLPM_RST_FTS_CC;
            fts_sc_r   <= `PLPM_RST_FTS_SC;
            l0s_acc_r  <= 3'h0;
            l1_acc_r   <= 3'h0;
            l1x_cc_r   <= `PLPM_RST_LAT;
            l1x_sc_r   <= `PLPM_RST_LAT;
            o_wb_ack   <= 1'b0;
            o_wb_dat   <= 32'h0;
        end
        else
        begin
            o_wb_ack <= wb_req;
            o_wb_dat <= 32'h0;
            if (wb_wr && i_wb_sel[0])
            begin
                case (i_wb_adr)
                    `PLPM_OFF_CTRL:    ctrl_r     <= i_wb_dat[2:0];
                    `PLPM_OFF_L0S_CFG: l0s_step_r <= i_wb_dat[4:0];
                    `PLPM_OFF_FTS_CFG: fts_cc_r   <= i_wb_dat[7:0];
                    `PLPM_OFF_LAT_CFG:
                    begin
                        l0s_acc_r <= i_wb_dat[2:0];
                        l1_acc_r  <= i_wb_dat[6:4];
                    end
                    default: ;                                                  // [R10]
                endcase
            end
            if (wb_wr && i_wb_sel[1])
            begin
                case (i_wb_adr)
                    `PLPM_OFF_FTS_CFG: fts_sc_r <= i_wb_dat[15:8];
                    `PLPM_OFF_LAT_CFG:
                    begin
                        l1x_cc_r <= i_wb_dat[10:8];
                        l1x_sc_r <= i_wb_dat[14:12];
                    end
                    default: ;
                endcase
            end
            if (wb_req && !i_wb_we)
            begin
                case (i_wb_adr)
                    `PLPM_OFF_CTRL:    o_wb_dat <= {29'h0, ctrl_r};
                    `PLPM_OFF_L0S_CFG: o_wb_dat <= {27'h0, l0s_step};
                    `PLPM_OFF_FTS_CFG: o_wb_dat <= {16'h0, fts_sc_r, fts_cc_r};
                    `PLPM_OFF_LAT_CFG: o_wb_dat <= {17'h0, l1x_sc_r, 1'b0, l1x_cc_r,
                                                    1'b0, l1_acc_r, 1'b0, l0s_acc_r};
                    `PLPM_OFF_DEVCAP:  o_wb_dat <= devcap;
                    `PLPM_OFF_LNKCAP:  o_wb_dat <= lnkcap;
                    `PLPM_OFF_STATUS:  o_wb_dat <= {23'h0, o_tx_l0s, fts_sent_r};
                    default:           o_wb_dat <= 32'h0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // L0s idle timer: 280 ns tick (7 cycles) from a cycle divider
    // ------------------------------------------------------------
    wire tick = (step_cnt_r == (`PLPM_L0S_STEP_CYC - 1));
    // Limitation: a whole-cycle tick stretches each step, so entry is never early

    always @*
    begin
        idle_cnt_nxt = idle_cnt_r;
        if (!i_link_idle)
            idle_cnt_nxt = 13'h0;                                               // [R1]
        // Stops at the threshold so a long idle spell cannot wrap the count
        else if (tick && idle_cnt_r < thresh)
            idle_cnt_nxt = idle_cnt_r + 13'h0001;
    end

    always @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            step_cnt_r     <= 6'h0;
            idle_cnt_r     <= 13'h0;
            o_tx_l0s       <= 1'b0;
            fts_sent_r     <= 8'h0;
            o_fts_count    <= 8'h0;
            o_l0s_exit_lat <= 3'h0;
            o_l1_exit_lat  <= 3'h0;
            o_aspm_l1_sup  <= 1'b0;
        end
        else
        begin
            // Restart the divider on activity so idle time is measured from its start
            step_cnt_r <= (!i_link_idle || tick) ? 6'h0 : step_cnt_r + 6'h01;
            idle_cnt_r <= idle_cnt_nxt;
            o_tx_l0s   <= i_link_idle && (idle_cnt_nxt >= thresh);              // [R1]
            if (i_link_init)
            begin
                // Count latched at init so it stays stable for the whole training
                fts_sent_r  <= fts_eff;                                         // [R4] [R5]
                o_fts_count <= fts_eff;
            end
            o_l0s_exit_lat <= l0sx;
            o_l1_exit_lat  <= l1x_eff;                                          // [R9]
            o_aspm_l1_sup  <= aspm_l1;                                          // [R6] [R7]
        end
    end

endmodule // plpm_top

`default_nettype wire

// File: tb/plpm_props.sv
// Purpose: Bus and L0s timing checks on plpm_top
// Assumes: One clock, synchronous active-high reset
// Notes:   PHY bit is shadowed from bus writes
`timescale 1ns/1ps
`default_nettype none
module plpm_props
(
    input wire logic        i_sys_clk,
    input wire logic        i_reset,
    input wire logic [7:0]  i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0]  i_wb_sel,
    input wire logic        i_wb_we,
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic        i_link_idle,
    input wire logic        i_link_init,
    input wire logic        o_wb_ack,
    input wire logic        o_tx_l0s,
    input wire logic [7:0]  o_fts_count,
    input wire logic        o_aspm_l1_sup
);
    logic       phy_r;
    logic [7:0] idle_r;
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            phy_r  <= 1'b0;
            idle_r <= 8'h00;
        end
        else
        begin
            if (i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack && i_wb_adr == 8'h00 && i_wb_sel[0])
                phy_r <= i_wb_dat[0];
            // Saturates so long idle spells do not wrap
            if (!i_link_idle)
                idle_r <= 8'h00;
            else if (idle_r != 8'hff)
                idle_r <= idle_r + 8'h01;
        end
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held");
    chk_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("no ack");
    chk_l0s_busy: assert property (!i_link_idle |=> !o_tx_l0s)
        else $error("l0s while busy");
    chk_l0s_hold: assert property (o_tx_l0s && i_link_idle |=> o_tx_l0s)
        else $error("l0s dropped");
    chk_l0s_early: assert property ($rose(o_tx_l0s) |-> idle_r >= 8'h07)
        else $error("l0s too early");
    chk_l0s_late: assert property (idle_r >= 8'he8 |-> o_tx_l0s)
        else $error("l0s too late");
    chk_fts_hold: assert property (!i_link_init |=> $stable(o_fts_count))
        else $error("fts moved");
    chk_phy_aspm: assert property (phy_r && $past(phy_r, 2) |-> !o_aspm_l1_sup)
        else $error("aspm with phy");
endmodule // plpm_props
bind plpm_top plpm_props u_props (.*);
`default_nettype wire

// File: tb/plpm_partner.sv
// Purpose: Upstream port model driving link idle and training
// Assumes: Same clock as the endpoint
// Notes:   Registers its controls, so it answers one cycle late
`timescale 1ns/1ps
`default_nettype none
module plpm_partner
(
    input  wire logic i_clk,
    input  wire logic i_quiet,
    input  wire logic i_train,
    output var  logic o_link_idle,
    output var  logic o_link_init
);
    initial o_link_idle = 1'b0;
    initial o_link_init = 1'b0;
    always @(posedge i_clk)
    begin
        o_link_idle <= i_quiet;
        o_link_init <= i_train;
    end
endmodule // plpm_partner
`default_nettype wire

// File: tb/plpm_tb.sv
// Purpose: Register and link tests of plpm_top
// Assumes: Ack comes one cycle after a request is taken
// Notes:   Expected codes worked from FTS times of 16 ns
`timescale 1ns/1ps
`default_nettype none
`include "plpm_regs.vh"
module testbench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0]  sel = 4'h0;
    logic        we = 1'b0;
    logic        stb = 1'b0;
    logic        quiet = 1'b0;
    logic        train = 1'b0;
    wire         idle;
    wire         init;
    wire  [31:0] rdat;
    wire         ack;
    wire         l0s;
    wire  [7:0]  fts;
    wire  [2:0]  l0x;
    wire  [2:0]  l1x;
    wire         asp;
    logic [31:0] rd;
    int          mismatches = 0;
    int          n_tests = 0;
    int          cycles = 0;
    always #20 clk = ~clk;
    plpm_partner u_partner (.i_clk(clk), .i_quiet(quiet), .i_train(train),
        .o_link_idle(idle), .o_link_init(init));
    plpm_top u_dut (.i_sys_clk(clk), .i_reset(rst), .i_wb_adr(adr), .i_wb_dat(wdat),
        .i_wb_sel(sel), .i_wb_we(we), .i_wb_cyc(stb), .i_wb_stb(stb),
        .i_link_idle(idle), .i_link_init(init), .o_wb_dat(rdat), .o_wb_ack(ack),
        .o_tx_l0s(l0s), .o_fts_count(fts), .o_l0s_exit_lat(l0x),
        .o_l1_exit_lat(l1x), .o_aspm_l1_sup(asp));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        adr <= a;
        we <= w;
        wdat <= d;
        sel <= 4'hf;
        stb <= 1'b1;
        @(posedge clk);
        while (ack !== 1'b1)
            @(posedge clk);
        rd = rdat;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
        @(posedge clk);
    endtask
    task automatic link_up();
        train <= 1'b1;
        @(posedge clk);
        train <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            complete_run();
        end
    end
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // ------------------------------------------------
        // Defaults, then L0s entry at the longest and shortest threshold
        // ------------------------------------------------
        wb(`PLPM_OFF_FTS_CFG, 1'b0, 32'h0);
        chk(rd, 32'h0000ffc8);
        quiet <= 1'b1;
        repeat (200) @(posedge clk);
        chk(l0s, 1'b0);
        repeat (40) @(posedge clk);
        chk(l0s, 1'b1);
        quiet <= 1'b0;
        wb(`PLPM_OFF_L0S_CFG, 1'b1, 32'h0);
        chk(l0s, 1'b0);
        quiet <= 1'b1;
        repeat (7) @(posedge clk);
        chk(l0s, 1'b0);
        repeat (5) @(posedge clk);
        chk(l0s, 1'b1);
        quiet <= 1'b0;
        // One busy cycle after a partial idle spell must restart the count
        wb(`PLPM_OFF_L0S_CFG, 1'b1, 32'h1);
        quiet <= 1'b1;
        repeat (10) @(posedge clk);
        quiet <= 1'b0;
        @(posedge clk);
        quiet <= 1'b1;
        repeat (12) @(posedge clk);
        chk(l0s, 1'b0);
        repeat (5) @(posedge clk);
        chk(l0s, 1'b1);
        quiet <= 1'b0;
        // ------------------------------------------------
        // FTS counts, exit codes and read-only capability fields
        // ------------------------------------------------
        wb(`PLPM_OFF_FTS_CFG, 1'b1, 32'h00001405);
        wb(`PLPM_OFF_LAT_CFG, 1'b1, 32'h00005223);
        link_up();
        chk({l1x, l0x, fts}, {3'h2, 3'h1, 8'h05});
        wb(`PLPM_OFF_CTRL, 1'b1, 32'h2);
        link_up();
        chk({l1x, l0x, fts}, {3'h5, 3'h3, 8'h14});
        wb(`PLPM_OFF_LNKCAP, 1'b0, 32'h0);
        chk(rd, 32'h0002b000);
        wb(`PLPM_OFF_CTRL, 1'b1, 32'h6);
        link_up();
        chk(asp, 1'b1);
        wb(`PLPM_OFF_DEVCAP, 1'b1, 32'hffffffff);
        wb(`PLPM_OFF_DEVCAP, 1'b0, 32'h0);
        chk(rd, 32'h000004c0);
        wb(8'h40, 1'b0, 32'h0);
        chk(rd, 32'h0);
        wb(`PLPM_OFF_CTRL, 1'b1, 32'h7);
        link_up();
        chk({asp, l1x, fts}, {1'b0, 3'h7, 8'hff});
        wb(`PLPM_OFF_L0S_CFG, 1'b0, 32'h0);
        chk(rd, 32'h0000001f);
        wb(`PLPM_OFF_STATUS, 1'b0, 32'h0);
        chk(rd, 32'h000000ff);
        // ------------------------------------------------
        // Reset in mid-run restores the defaults
        // ------------------------------------------------
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({l0s, asp, l1x, l0x, fts}, 32'h0);
        wb(`PLPM_OFF_CTRL, 1'b0, 32'h0);
        chk(rd, 32'h0);
        chk({l1x, l0x}, {3'h7, 3'h6});
        complete_run();
    end
endmodule // testbench
`default_nettype wire
